// File: bench/testbench.sv
// Self-checking testbench of the actuator status indicator
`timescale 1ns/10ps
module testbench;
  import actuator_status_pkg::*;

  // ----------------------------------------
  // Signals and scoreboard
  // ----------------------------------------
  localparam int TC = 4;  // Short tick keeps the run brief
  localparam int MR = 60;
  logic             clock;
  logic             rst_n;
  logic             clk_en;
  pins_t            pins;
  logic             mode_reverse;
  logic [CMD_W-1:0] cmd_level;
  logic [CMD_W-1:0] target_pos;
  led_t             leds;
  logic             power_led;
  logic             relay_closed;
  logic             heater_resistor;
  logic             motor_enable;
  int               err_count;
  int               cmp_count;
  int               n;
  int               w;
  logic [31:0]      got_q[$];
  logic [31:0]      exp_q[$];

  actuator_status #(.TICK_CYC(TC), .MAX_RUN(MR)) actuator_status_i (
    .clock(clock), .rst_n(rst_n), .clk_en(clk_en), .pins(pins),
    .mode_reverse(mode_reverse), .cmd_level(cmd_level), .leds(leds),
    .power_led(power_led), .relay_closed(relay_closed),
    .heater_resistor(heater_resistor), .motor_enable(motor_enable),
    .target_pos(target_pos));

  // Free-running clock
  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  // Monitor pairs each observation with the oldest expectation
  initial forever begin
    @(posedge clock);
    while (got_q.size() > 0) check(got_q.pop_front(), exp_q.pop_front());
  end

  task automatic note(input logic [31:0] g, input logic [31:0] e);
    got_q.push_back(g);
    exp_q.push_back(e);
  endtask : note

  task automatic cyc(input int k);
    repeat (k) @(negedge clock);
  endtask : cyc

  // Relay, heater, power lamp, motor enable
  function automatic logic [3:0] st();
    return {relay_closed, heater_resistor, power_led, motor_enable};
  endfunction : st

  // Length of the next run of lamp bit b at level lv, bounded
  task automatic pulse(input int b, input logic lv, output int w);
    int g;
    g = 0;
    w = 0;
    while (leds[b] === lv && g < 3000) begin @(negedge clock); g++; end
    while (leds[b] !== lv && g < 3000) begin @(negedge clock); g++; end
    while (leds[b] === lv && g < 3000) begin @(negedge clock); g++; w++; end
  endtask : pulse

  // Red flashes in one cycle; a dark run over 20 cycles is a gap
  task automatic flashes(output int n);
    int   q;
    int   g;
    logic p;
    n = 0;
    q = 0;
    g = 0;
    p = 1'b0;
    while (q <= 20 && g < 2000) begin
      @(negedge clock); g++;
      q = (leds.red === 1'b1) ? 0 : q + 1;
    end
    q = 0;
    while ((n == 0 || q <= 20) && g < 4000) begin
      @(negedge clock); g++;
      if (leds.red === 1'b1 && !p) n++;
      p = (leds.red === 1'b1);
      q = p ? 0 : q + 1;
    end
  endtask : flashes

  task automatic report_and_stop();
    cyc(2);
    $display("Comparisons %0d, mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : report_and_stop

  // Watchdog sized well above the planned sequence
  initial begin
    #(40000 * 8);
    err_count++;
    report_and_stop();
  end

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    pins = '0; mode_reverse = 1'b0; cmd_level = '0; clk_en = 1'b1; rst_n = 1'b0;
    err_count = 0; cmp_count = 0;
    w = $urandom(32'h618E);
    cyc(8); rst_n = 1'b1; cyc(1);
    note({st(), leds}, 7'h00);
    // Powered and idle in standard mode
    pins.supply_present = 1'b1; cyc(5);
    note(st(), 4'hF);
    pulse(2, 1'b1, w); note(w, STD_IDLE_ON * TC);
    pulse(2, 0, w); note(w, STD_IDLE_OFF * TC);
    note(leds.yellow, 0);
    repeat (8) begin
      cmd_level = CMD_W'($urandom); mode_reverse = 1'($urandom); cyc(1);
      note(target_pos, CMD_W'(mode_reverse ? ~cmd_level : cmd_level));
    end
    // Clock enable low freezes the heater output
    mode_reverse = 1'b0; clk_en = 1'b0; pins.temp_above_limit = 1'b1; cyc(5);
    note(heater_resistor, 1);
    clk_en = 1'b1; cyc(5);
    note(heater_resistor, 0);
    pins.temp_above_limit = 1'b0;
    $display("test idle done");
    // Rotation and reverse mode timings
    for (int m = 0; m < 2; m++) begin
      mode_reverse = m[0]; pins.motor_running = 1'b1; cyc(5);
      note(st(), 4'hB);
      pulse(2, 1'b1, w); note(w, (m ? REV_RUN_ON : STD_RUN_ON) * TC);
      pulse(2, 0, w); note(w, (m ? REV_RUN_OFF : STD_RUN_OFF) * TC);
      pins.motor_running = 1'b0; cyc(5);
    end
    pulse(2, 1'b1, w); note(w, REV_IDLE_ON * TC);
    pulse(2, 0, w); note(w, REV_IDLE_OFF * TC);
    pins.supply_present = 1'b0; cyc(5);
    note({relay_closed, heater_resistor, power_led}, 3'h0);
    pulse(1, 1'b1, w); note(w, REV_IDLE_ON * TC);
    note(leds.green, 0);
    pins.supply_present = 1'b1; mode_reverse = 1'b0;
    $display("test modes done");
    // Self-clearing anomalies: undervoltage, manual, both
    for (int k = 0; k < 3; k++) begin
      pins = (k == 0) ? 7'h50 : (k == 1) ? 7'h44 : 7'h54; cyc(5);
      note({relay_closed, motor_enable}, 2'b00);
      flashes(n); note(n, (k == 1) ? CODE_MANUAL : CODE_UNDERV);
      pulse(0, 1'b1, w); note(w, ((k == 1) ? OTH_ON : UV_ON) * TC);
      pins = 7'h40; cyc(5);
      note({relay_closed, motor_enable}, 2'b11);
    end
    $display("test resumable done");
    // Latched anomalies and priority
    pins.driver_fault = 1'b1; cyc(2); pins.driver_fault = 1'b0; cyc(5);
    note({relay_closed, motor_enable}, 2'b00);
    flashes(n); note(n, CODE_DRIVER);
    pins.torque_limit = 1'b1; cyc(2); pins.torque_limit = 1'b0; cyc(5);
    flashes(n); note(n, CODE_TORQUE);
    rst_n = 1'b0; cyc(2); rst_n = 1'b1; cyc(5);
    note({relay_closed, motor_enable}, 2'b11);
    $display("test latches done");
    // Continuous running past the limit
    pins.motor_running = 1'b1; cyc(MR * TC + 2 * TC + 6);
    note({relay_closed, motor_enable}, 2'b00);
    pins.motor_running = 1'b0; cyc(5);
    flashes(n); note(n, CODE_TIMEOUT);
    pulse(0, 1'b1, w); note(w, TO_ON * TC);
    note(relay_closed, 0);
    $display("test timeout done");
    report_and_stop();
  end

endmodule : testbench

// File: pkg/actuator_status_pkg.sv
// Constants, carriers and state types of the actuator status indicator
package actuator_status_pkg;

  // ---------------------------------------------------------------
  // Timebase
  // ---------------------------------------------------------------
  localparam int CLK_HZ      = 125_000_000;
  localparam int TICK_MS     = 100;
  localparam int TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;
  localparam int TICK_CNT_W  = 24;
  localparam int TW          = 6;   // width of a duration in ticks
  localparam int CW          = 3;   // width of a flash count
  localparam int CMD_W       = 10;  // width of the command level
  localparam int RUN_W       = 16;  // width of the run-time counter
  localparam int MAX_RUN_TK  = 600; // maximum working time, ticks

  // ---------------------------------------------------------------
  // Durations in ms and in ticks
  // ---------------------------------------------------------------
  localparam int STD_IDLE_ON_MS  = 100;
  localparam int STD_IDLE_OFF_MS = 900;
  localparam int STD_RUN_ON_MS   = 600;
  localparam int STD_RUN_OFF_MS  = 400;
  localparam int REV_IDLE_ON_MS  = 100;
  localparam int REV_IDLE_OFF_MS = 400;
  localparam int REV_RUN_ON_MS   = 300;
  localparam int REV_RUN_OFF_MS  = 200;
  localparam int UV_ON_MS        = 400;
  localparam int UV_OFF_MS       = 200;
  localparam int UV_GAP_MS       = 4000;
  localparam int TO_ON_MS        = 100;
  localparam int TO_OFF_MS       = 300;
  localparam int TO_GAP_MS       = 1000;
  localparam int OTH_ON_MS       = 300;
  localparam int OTH_OFF_MS      = 300;
  localparam int OTH_GAP_MS      = 2000;

  localparam logic [TW-1:0] STD_IDLE_ON  = TW'(STD_IDLE_ON_MS / TICK_MS);
  localparam logic [TW-1:0] STD_IDLE_OFF = TW'(STD_IDLE_OFF_MS / TICK_MS);
  localparam logic [TW-1:0] STD_RUN_ON   = TW'(STD_RUN_ON_MS / TICK_MS);
  localparam logic [TW-1:0] STD_RUN_OFF  = TW'(STD_RUN_OFF_MS / TICK_MS);
  localparam logic [TW-1:0] REV_IDLE_ON  = TW'(REV_IDLE_ON_MS / TICK_MS);
  localparam logic [TW-1:0] REV_IDLE_OFF = TW'(REV_IDLE_OFF_MS / TICK_MS);
  localparam logic [TW-1:0] REV_RUN_ON   = TW'(REV_RUN_ON_MS / TICK_MS);
  localparam logic [TW-1:0] REV_RUN_OFF  = TW'(REV_RUN_OFF_MS / TICK_MS);
  localparam logic [TW-1:0] UV_ON        = TW'(UV_ON_MS / TICK_MS);
  localparam logic [TW-1:0] UV_OFF       = TW'(UV_OFF_MS / TICK_MS);
  localparam logic [TW-1:0] UV_GAP       = TW'(UV_GAP_MS / TICK_MS);
  localparam logic [TW-1:0] TO_ON        = TW'(TO_ON_MS / TICK_MS);
  localparam logic [TW-1:0] TO_OFF       = TW'(TO_OFF_MS / TICK_MS);
  localparam logic [TW-1:0] TO_GAP       = TW'(TO_GAP_MS / TICK_MS);
  localparam logic [TW-1:0] OTH_ON       = TW'(OTH_ON_MS / TICK_MS);
  localparam logic [TW-1:0] OTH_OFF      = TW'(OTH_OFF_MS / TICK_MS);
  localparam logic [TW-1:0] OTH_GAP      = TW'(OTH_GAP_MS / TICK_MS);

  // ---------------------------------------------------------------
  // Flash counts per anomaly, zero meaning none
  // ---------------------------------------------------------------
  localparam logic [CW-1:0] CODE_NONE    = 3'h0;
  localparam logic [CW-1:0] CODE_TORQUE  = 3'h1;
  localparam logic [CW-1:0] CODE_UNDERV  = 3'h3;
  localparam logic [CW-1:0] CODE_TIMEOUT = 3'h4;
  localparam logic [CW-1:0] CODE_DRIVER  = 3'h5;
  localparam logic [CW-1:0] CODE_MANUAL  = 3'h6;
  localparam logic [CW-1:0] BLINK_COUNT  = 3'h1;

  // ---------------------------------------------------------------
  // Carriers
  // ---------------------------------------------------------------
  typedef struct packed {
    logic supply_present;
    logic torque_limit;
    logic undervoltage;
    logic driver_fault;
    logic manual_operation;
    logic motor_running;
    logic temp_above_limit;
  } pins_t;

  typedef struct packed {
    logic green;
    logic yellow;
    logic red;
  } led_t;

  typedef struct packed {
    logic [CW-1:0] count;
    logic [TW-1:0] on_t;
    logic [TW-1:0] off_t;
    logic [TW-1:0] gap_t;
  } pattern_t;

  typedef enum logic [3:0] {
    FS_IDLE = 4'h1,
    FS_ON   = 4'h2,
    FS_OFF  = 4'h4,
    FS_GAP  = 4'h8
  } flash_st_t;

  // ---------------------------------------------------------------
  // Module state
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [TICK_CNT_W-1:0] cnt;
    logic                  tick;
  } tick_state_t;

  typedef struct packed {
    flash_st_t     st;
    logic [TW-1:0] timer;
    logic [CW-1:0] nflash;
    logic          led;
  } flash_state_t;

  typedef struct packed {
    pins_t            sync1;
    pins_t            sync2;
    logic             mode_rev;
    logic             torque_lat;
    logic             timeout_lat;
    logic             driver_lat;
    logic [RUN_W-1:0] run_cnt;
    logic [CW-1:0]    code;
    led_t             leds;
    logic             power_led;
    logic             relay;
    logic             heater;
    logic             motor_en;
    logic [CMD_W-1:0] target;
  } main_state_t;

endpackage : actuator_status_pkg

// File: src/actuator_status.sv
// Status lamps, fault relay, heater and motor enable of the valve actuator
`timescale 1ns/10ps
module actuator_status #(
  parameter int TICK_CYC = actuator_status_pkg::TICK_CYCLES,
  parameter int MAX_RUN  = actuator_status_pkg::MAX_RUN_TK
) (
  // Clock and reset
  input  wire logic                                   clock,
  input  wire logic                                   rst_n,
  input  wire logic                                   clk_en,
  // Field inputs, asynchronous
  input  wire actuator_status_pkg::pins_t             pins,
  // Command path, same clock
  input  wire logic                                   mode_reverse,
  input  wire logic [actuator_status_pkg::CMD_W-1:0]  cmd_level,
  // Lamps and contacts
  output actuator_status_pkg::led_t                   leds,
  output logic                                        power_led,
  output logic                                        relay_closed,
  output logic                                        heater_resistor,
  // Motor control
  output logic                                        motor_enable,
  output logic [actuator_status_pkg::CMD_W-1:0]       target_pos
);
  import actuator_status_pkg::*;

  localparam logic [RUN_W-1:0] RUN_LIMIT = RUN_W'(MAX_RUN);

  main_state_t q;
  main_state_t d;
  pins_t       s;
  logic        tick;
  logic        blocked;
  logic        anomaly;
  logic [CW-1:0] code_sel;
  pattern_t    blink_pat;
  pattern_t    red_pat;
  logic        blink_led;
  logic        red_led;

  // ---------------------------------------------------------------
  // Timebase and sequencers
  // ---------------------------------------------------------------
  status_tick #(
    .TICK_CYC (TICK_CYC)
  ) u_tick (
    .clock  (clock),
    .rst_n  (rst_n),
    .clk_en (clk_en),
    .tick   (tick)
  );

  flash_seq u_blink (
    .clock   (clock),
    .rst_n   (rst_n),
    .clk_en  (clk_en),
    .tick    (tick),
    .enable  (!anomaly),
    .restart (1'b0),
    .pat     (blink_pat),
    .led     (blink_led)
  );

  // Restart on a code change so a new code starts with its first flash
  flash_seq u_red (
    .clock   (clock),
    .rst_n   (rst_n),
    .clk_en  (clk_en),
    .tick    (tick),
    .enable  (anomaly),
    .restart (code_sel != q.code),
    .pat     (red_pat),
    .led     (red_led)
  );

  // ---------------------------------------------------------------
  // Code selection and patterns
  // ---------------------------------------------------------------
  assign s       = q.sync2;
  assign blocked = q.torque_lat | q.timeout_lat | q.driver_lat;
  assign anomaly = (code_sel != CODE_NONE);

  always_comb begin
    if (q.torque_lat) begin
      code_sel = CODE_TORQUE;
    end else if (q.timeout_lat) begin
      code_sel = CODE_TIMEOUT;
    end else if (q.driver_lat) begin
      code_sel = CODE_DRIVER;
    end else if (s.undervoltage) begin
      code_sel = CODE_UNDERV;
    end else if (s.manual_operation) begin
      code_sel = CODE_MANUAL;
    end else begin
      code_sel = CODE_NONE;
    end
  end

  // mode patterns; supply loss keeps the same timing
  always_comb begin
    blink_pat.count = BLINK_COUNT;
    unique case ({q.mode_rev, s.motor_running})
      2'b00: begin
        blink_pat.on_t  = STD_IDLE_ON;
        blink_pat.off_t = STD_IDLE_OFF;
      end
      2'b01: begin
        blink_pat.on_t  = STD_RUN_ON;
        blink_pat.off_t = STD_RUN_OFF;
      end
      2'b10: begin
        blink_pat.on_t  = REV_IDLE_ON;
        blink_pat.off_t = REV_IDLE_OFF;
      end
      2'b11: begin
        blink_pat.on_t  = REV_RUN_ON;
        blink_pat.off_t = REV_RUN_OFF;
      end
    endcase
    blink_pat.gap_t = blink_pat.off_t; // single flash, gap is the pause
  end

  always_comb begin
    red_pat.count = code_sel;
    unique case (code_sel)
      CODE_UNDERV: begin
        red_pat.on_t  = UV_ON;
        red_pat.off_t = UV_OFF;
        red_pat.gap_t = UV_GAP;
      end
      CODE_TIMEOUT: begin
        red_pat.on_t  = TO_ON;
        red_pat.off_t = TO_OFF;
        red_pat.gap_t = TO_GAP;
      end
      default: begin
        red_pat.on_t  = OTH_ON;
        red_pat.off_t = OTH_OFF;
        red_pat.gap_t = OTH_GAP;
      end
    endcase
  end

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb begin
    d = q;
    // Two stages before any logic sees a field pin
    d.sync1 = pins;
    d.sync2 = q.sync1;
    // mode follows the selector, reset is standard
    d.mode_rev = mode_reverse;
    d.target   = mode_reverse ? ~cmd_level : cmd_level;
    // continuous run time, cleared whenever the motor stops
    if (!s.motor_running || !q.motor_en) begin
      d.run_cnt = '0;
    end else if (tick && q.run_cnt < RUN_LIMIT) begin
      d.run_cnt = q.run_cnt + 1'b1;
    end
    d.torque_lat  = q.torque_lat | s.torque_limit;
    d.driver_lat  = q.driver_lat | s.driver_fault;
    d.timeout_lat = q.timeout_lat | (s.motor_running && q.run_cnt >= RUN_LIMIT);
    // undervoltage and manual stop without latching
    d.motor_en = s.supply_present & ~(d.torque_lat | d.driver_lat | d.timeout_lat)
               & ~s.undervoltage & ~s.manual_operation;
    d.code = code_sel;
    // yellow while supply is gone, red takes the lamp on anomaly
    d.leds.green  = !anomaly && s.supply_present && blink_led;
    d.leds.yellow = !anomaly && !s.supply_present && blink_led;
    d.leds.red    = anomaly && red_led;
    // relay closed only when powered and clean
    d.relay = s.supply_present && !anomaly;
    d.power_led = s.supply_present;
    // heater only when cold, still and powered
    d.heater = s.supply_present && !s.motor_running && !s.temp_above_limit;
  end

  // State register, frozen while the enable is low
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      q <= '0;
    end else if (clk_en) begin
      q <= d;
    end
  end

  // Outputs straight from the state register
  assign leds            = q.leds;
  assign power_led       = q.power_led;
  assign relay_closed    = q.relay;
  assign heater_resistor = q.heater;
  assign motor_enable    = q.motor_en;
  assign target_pos      = q.target;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  // standard idle timing
  property p_std_idle;
    @(posedge clock) disable iff (!rst_n)
      (!q.mode_rev && !s.motor_running) |-> (blink_pat.on_t == 6'h01 && blink_pat.off_t == 6'h09);
  endproperty
  a_std_idle: assert property (p_std_idle) else $error("standard idle timing wrong");

  property p_rev_run;
    @(posedge clock) disable iff (!rst_n)
      (q.mode_rev && s.motor_running) |-> (blink_pat.on_t == 6'h03 && blink_pat.off_t == 6'h02);
  endproperty
  a_rev_run: assert property (p_rev_run) else $error("reverse run timing wrong");

  property p_yellow;
    @(posedge clock) disable iff (!rst_n)
      (clk_en && !s.supply_present) |=> !q.leds.green;
  endproperty
  a_yellow: assert property (p_yellow) else $error("green lit without supply");

  property p_yellow_on;
    @(posedge clock) disable iff (!rst_n)
      (clk_en && !s.supply_present && !anomaly && blink_led) |=> q.leds.yellow;
  endproperty
  a_yellow_on: assert property (p_yellow_on) else $error("yellow dark on supply loss");

  property p_torque_block;
    @(posedge clock) disable iff (!rst_n)
      (clk_en && q.torque_lat) |=> (!q.motor_en && q.code == CODE_TORQUE);
  endproperty
  a_torque_block: assert property (p_torque_block) else $error("torque did not block");

  property p_driver_block;
    @(posedge clock) disable iff (!rst_n)
      (clk_en && q.driver_lat) |=> !q.motor_en;
  endproperty
  a_driver_block: assert property (p_driver_block) else $error("driver fault did not block");

  property p_uv_timing;
    @(posedge clock) disable iff (!rst_n)
      (code_sel == CODE_UNDERV) |-> (red_pat.on_t == 6'h04 && red_pat.gap_t == 6'h28);
  endproperty
  a_uv_timing: assert property (p_uv_timing) else $error("undervoltage timing wrong");

  property p_to_gap;
    @(posedge clock) disable iff (!rst_n)
      (code_sel == CODE_TIMEOUT) |-> (red_pat.count == 3'h4 && red_pat.gap_t == 6'h0A);
  endproperty
  a_to_gap: assert property (p_to_gap) else $error("timeout pattern wrong");

  property p_resume;
    @(posedge clock) disable iff (!rst_n)
      (clk_en && s.supply_present && !blocked && !s.undervoltage && !s.manual_operation
       && !s.torque_limit && !s.driver_fault && !(s.motor_running && q.run_cnt >= RUN_LIMIT))
      |=> q.motor_en;
  endproperty
  a_resume: assert property (p_resume) else $error("motor not re-enabled");

  property p_relay;
    @(posedge clock) disable iff (!rst_n)
      (clk_en && (anomaly || !s.supply_present)) |=> !q.relay;
  endproperty
  a_relay: assert property (p_relay) else $error("relay closed on anomaly");

  property p_heater;
    @(posedge clock) disable iff (!rst_n)
      (clk_en && (s.motor_running || s.temp_above_limit)) |=> !q.heater;
  endproperty
  a_heater: assert property (p_heater) else $error("heater on while hot or running");

  property p_power_led;
    @(posedge clock) disable iff (!rst_n)
      (clk_en && s.supply_present) |=> q.power_led;
  endproperty
  a_power_led: assert property (p_power_led) else $error("power lamp dark");

  property p_mapping;
    @(posedge clock) disable iff (!rst_n)
      (clk_en && !mode_reverse) |=> (q.target == $past(cmd_level));
  endproperty
  a_mapping: assert property (p_mapping) else $error("standard mapping inverted");

  property p_timeout;
    @(posedge clock) disable iff (!rst_n)
      (clk_en && s.motor_running && q.run_cnt >= RUN_LIMIT) |=> (q.timeout_lat && !q.motor_en);
  endproperty
  a_timeout: assert property (p_timeout) else $error("timeout not raised");

  property p_latch;
    @(posedge clock) disable iff (!rst_n)
      (clk_en && blocked) |=> (blocked && !q.relay);
  endproperty
  a_latch: assert property (p_latch) else $error("blocking anomaly released");

  property p_priority;
    @(posedge clock) disable iff (!rst_n)
      (q.timeout_lat && !q.torque_lat) |-> (code_sel == CODE_TIMEOUT);
  endproperty
  a_priority: assert property (p_priority) else $error("wrong code shown");

endmodule : actuator_status

// File: src/flash_seq.sv
// Flash sequencer: count flashes of on time, pauses between, gap per cycle
`timescale 1ns/10ps
module flash_seq (
  // Clock and reset
  input  wire logic                          clock,
  input  wire logic                          rst_n,
  input  wire logic                          clk_en,
  input  wire logic                          tick,
  // Pattern control
  input  wire logic                          enable,
  input  wire logic                          restart,
  input  wire actuator_status_pkg::pattern_t pat,
  // Lamp drive
  output logic                               led
);
  import actuator_status_pkg::*;

  flash_state_t q;
  flash_state_t d;

  // Next state; a timer value of one or less ends the phase on a tick
  always_comb begin
    d = q;
    if (!enable || restart) begin
      d.st  = FS_IDLE;
      d.led = 1'b0;
    end else begin
      unique case (q.st)
        FS_IDLE: begin
          d.st     = FS_ON;
          d.timer  = pat.on_t;
          d.nflash = 3'h1;
          d.led    = 1'b1;
        end
        FS_ON: if (tick) begin
          if (q.timer <= 6'h01) begin
            d.led   = 1'b0;
            d.st    = (q.nflash >= pat.count) ? FS_GAP : FS_OFF;
            d.timer = (q.nflash >= pat.count) ? pat.gap_t : pat.off_t;
          end else begin
            d.timer = q.timer - 1'b1;
          end
        end
        FS_OFF: if (tick) begin
          if (q.timer <= 6'h01) begin
            d.st     = FS_ON;
            d.led    = 1'b1;
            d.timer  = pat.on_t;
            d.nflash = q.nflash + 1'b1;
          end else begin
            d.timer = q.timer - 1'b1;
          end
        end
        FS_GAP: if (tick) begin
          if (q.timer <= 6'h01) begin
            // Straight into the next first flash; an idle cycle here would
            // stretch every gap by one clock
            d.st     = FS_ON;
            d.led    = 1'b1;
            d.timer  = pat.on_t;
            d.nflash = 3'h1;
          end else begin
            d.timer = q.timer - 1'b1;
          end
        end
        default: d.st = FS_IDLE;
      endcase
    end
  end

  // State register
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      q <= '{st: FS_IDLE, timer: '0, nflash: '0, led: 1'b0};
    end else if (clk_en) begin
      q <= d;
    end
  end

  assign led = q.led;

  property p_on_load;
    @(posedge clock) disable iff (!rst_n)
      $rose(q.led) |-> (q.timer == $past(pat.on_t));
  endproperty
  a_on_load: assert property (p_on_load) else $error("flash on time not loaded");

  property p_count_bound;
    @(posedge clock) disable iff (!rst_n)
      (q.st == FS_ON && !restart) |-> (q.nflash <= pat.count);
  endproperty
  a_count_bound: assert property (p_count_bound) else $error("too many flashes");

endmodule : flash_seq

// File: src/status_tick.sv
// Tick generator dividing the system clock down to the pattern timebase
`timescale 1ns/10ps
module status_tick #(
  parameter int TICK_CYC = actuator_status_pkg::TICK_CYCLES
) (
  // Clock and reset
  input  wire logic clock,
  input  wire logic rst_n,
  input  wire logic clk_en,
  // Timebase
  output logic      tick
);
  import actuator_status_pkg::*;

  localparam logic [TICK_CNT_W-1:0] LAST = TICK_CNT_W'(TICK_CYC - 1);

  tick_state_t q;
  tick_state_t d;

  // Count to the period, one-cycle pulse at the wrap
  always_comb begin
    d = q;
    d.tick = 1'b0;
    if (q.cnt >= LAST) begin
      d.cnt  = '0;
      d.tick = 1'b1;
    end else begin
      d.cnt = q.cnt + 1'b1;
    end
  end

  // State register, frozen while the enable is low
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      q <= '0;
    end else if (clk_en) begin
      q <= d;
    end
  end

  assign tick = q.tick;

endmodule : status_tick
